// ---- design/tcc_pkg.sv ----
// package: register map, field positions and codes for the two-channel capture/compare block
package tcc_pkg;
    // register byte addresses (one aligned word each)
    localparam logic [7:0] CH0_CTRL_ADDR = 8'h00;
    localparam logic [7:0] CH1_CTRL_ADDR = 8'h04;
    localparam logic [7:0] CH0_HI_ADDR   = 8'h08;
    localparam logic [7:0] CH0_LO_ADDR   = 8'h0c;
    localparam logic [7:0] CH1_HI_ADDR   = 8'h10;
    localparam logic [7:0] CH1_LO_ADDR   = 8'h14;
    // control/status field positions
    localparam int FLAG_BIT = 7;
    localparam int IE_BIT   = 6;
    localparam int MSB_BIT  = 5;
    localparam int MSA_BIT  = 4;
    localparam int ELSB_BIT = 3;
    localparam int ELSA_BIT = 2;
    localparam int TOV_BIT  = 1;
    localparam int MAX_BIT  = 0;
    // edge/level codes
    localparam logic [1:0] EL_OFF  = 2'h0;
    localparam logic [1:0] EL_RISE = 2'h1;
    localparam logic [1:0] EL_FALL = 2'h2;
    localparam logic [1:0] EL_BOTH = 2'h3;
    // ahb transfer type
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    // channel modes
    typedef enum {MODE_PORT, MODE_CAPTURE, MODE_COMPARE, MODE_BUFFERED} mode_t;
endpackage : tcc_pkg

// ---- design/tcc_channels.sv ----
// two-channel timer capture/compare logic with an ahb-lite register slave
// How it works
// - channel 0 buffer select disables channel 1 control and frees its pin
// - with edge field nonzero and no buffering, mode bit picks capture or compare
// - edge field zero: pin under port control, inverted mode bit gives initial level
// - edge field zero disconnects the channel from its pin
// - capture edge: 01 rising, 10 falling, 11 either
// - compare match: 01 toggles, 10 drives low, 11 drives high
// - buffer select set with edge field nonzero means buffered compare regardless of mode bit
// - reset clears edge, mode, buffer and toggle bits
// - toggle-on-overflow toggles compare output at overflow, no effect in capture
// - with toggle set, overflow action beats a coincident compare action
// - toggle plus max-duty forces pwm output to full duty
// - max-duty changes take effect from the next pwm period
// - value registers hold capture or compare value, reset clears them to zero
// - capture: high byte read blocks captures until low byte read
// - compare: high byte write blocks matches until low byte written
// - event flag set on capture edge or counter equal to channel value
// - flag cleared by read-with-flag-set then write zero, new event wins
// - interrupt request when flag and enable both set; reset clears enable
// - overflow event arrives as input when counter reaches modulo
module tcc_channels
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // shared counter
    input  wire logic [15:0] count,
    input  wire logic        overflow,
    // channel pins
    input  wire logic [1:0]  channel_pin_in,
    output logic      [1:0]  channel_pin_out,
    output logic      [1:0]  channel_pin_oe,
    // interrupt requests
    output logic      [1:0]  chan_irq
);
    typedef struct packed {
        logic [1:0]  ahb_pend;     // [0] write, [1] active
        logic [7:0]  ahb_addr;
        logic [31:0] rdata;
        logic [1:0]  flag;
        logic [1:0]  irq_en;
        logic        chan0_buffer_select;
        logic [1:0]  unbuffered_mode_select;
        logic [1:0]  edge_level_select_hi;
        logic [1:0]  edge_level_select_lo;
        logic [1:0]  toggle_on_overflow;
        logic [1:0]  max_duty_force;
        logic [1:0]  max_act;      // max-duty as applied this period
        logic [1:0]  flag_armed;   // read with flag set seen
        logic [1:0]  cap_block;
        logic [1:0]  cmp_block;
        logic [1:0]  hi_wbuf_v;
        logic [15:0] val0;
        logic [15:0] val1;
        logic [7:0]  hi_wbuf0;
        logic [7:0]  hi_wbuf1;
        logic [7:0]  lo_latch0;
        logic [7:0]  lo_latch1;
        logic        buf_sel;      // active value register in buffered mode
        logic [1:0]  pin_q;
        logic [1:0]  pin_oe;
        logic [1:0]  sync1;
        logic [1:0]  sync2;
        logic [1:0]  prev_in;
        logic [1:0]  irq;
    } state_t;

    state_t s_q;
    state_t s_d;

    // decode channel mode from control bits
    function automatic tcc_pkg::mode_t mode_of(input logic b, input logic a,
                                               input logic [1:0] el);
        if (el == tcc_pkg::EL_OFF)
            return tcc_pkg::MODE_PORT;
        else if (b)
            return tcc_pkg::MODE_BUFFERED;
        else if (a)
            return tcc_pkg::MODE_COMPARE;
        else
            return tcc_pkg::MODE_CAPTURE;
    endfunction : mode_of

    // compare-match pin action
    function automatic logic match_level(input logic [1:0] el, input logic cur);
        unique case (el)
            tcc_pkg::EL_RISE: return ~cur;
            tcc_pkg::EL_FALL: return 1'b0;
            tcc_pkg::EL_BOTH: return 1'b1;
            default:          return cur;
        endcase
    endfunction : match_level

    tcc_pkg::mode_t mode0;
    tcc_pkg::mode_t mode1;
    logic [1:0]     el0;
    logic [1:0]     el1;
    logic           take;

    assign el0   = {s_q.edge_level_select_hi[0], s_q.edge_level_select_lo[0]};
    assign el1   = {s_q.edge_level_select_hi[1], s_q.edge_level_select_lo[1]};
    assign mode0 = mode_of(s_q.chan0_buffer_select, s_q.unbuffered_mode_select[0], el0);
    // channel 1 idles as a port pin while channel 0 is buffered
    assign mode1 = s_q.chan0_buffer_select ? tcc_pkg::MODE_PORT
                 : mode_of(1'b0, s_q.unbuffered_mode_select[1], el1);
    assign take  = hsel && hready && htrans == tcc_pkg::HTRANS_NONSEQ;

    // next-state logic
    always_comb
    begin
        logic [1:0]  rise;
        logic [1:0]  fall;
        logic [1:0]  edge_hit;
        logic [1:0]  match;
        logic [15:0] cmpv0;
        logic [15:0] cmpv1;
        logic [7:0]  wb;
        logic [1:0]  ev;           // flag-setting event this cycle
        int          c;
        logic [1:0]  el [2];
        tcc_pkg::mode_t md [2];
        rise     = '0;
        fall     = '0;
        edge_hit = '0;
        match    = '0;
        ev       = '0;
        c        = 0;
        cmpv0    = '0;
        cmpv1    = '0;
        wb       = hwdata[7:0];
        el[0]    = el0;
        el[1]    = el1;
        md[0]    = mode0;
        md[1]    = mode1;
        s_d      = s_q;
        s_d.sync1   = channel_pin_in;
        s_d.sync2   = s_q.sync1;
        s_d.prev_in = s_q.sync2;
        rise = s_q.sync2 & ~s_q.prev_in;
        fall = ~s_q.sync2 & s_q.prev_in;
        // buffered mode compares against the active register
        cmpv0 = (mode0 == tcc_pkg::MODE_BUFFERED && s_q.buf_sel) ? s_q.val1 : s_q.val0;
        cmpv1 = s_q.val1;
        match[0] = count == cmpv0 && !s_q.cmp_block[0];
        match[1] = count == cmpv1 && !s_q.cmp_block[1];
        if (mode0 == tcc_pkg::MODE_BUFFERED && s_q.buf_sel)
            match[0] = count == cmpv0 && !s_q.cmp_block[1];
        if (overflow && mode0 == tcc_pkg::MODE_BUFFERED)
            s_d.buf_sel = ~s_q.buf_sel;
        for (int i = 0; i < 2; i++)
        begin
            // capture edge selection
            unique case (el[i])
                tcc_pkg::EL_RISE: edge_hit[i] = rise[i];
                tcc_pkg::EL_FALL: edge_hit[i] = fall[i];
                tcc_pkg::EL_BOTH: edge_hit[i] = rise[i] | fall[i];
                default:          edge_hit[i] = 1'b0;
            endcase
            if (overflow)
                s_d.max_act[i] = s_q.max_duty_force[i];
            s_d.pin_oe[i] = 1'b1;
            unique case (md[i])
                tcc_pkg::MODE_PORT:
                begin
                    s_d.pin_oe[i] = 1'b0;
                    s_d.pin_q[i]  = ~s_q.unbuffered_mode_select[i];
                end
                tcc_pkg::MODE_CAPTURE:
                begin
                    s_d.pin_oe[i] = 1'b0;
                    if (edge_hit[i] && !s_q.cap_block[i])
                    begin
                        s_d.flag[i] = 1'b1;
                        s_d.flag_armed[i] = 1'b0;
                        ev[i]       = 1'b1;
                        if (i == 0)
                            s_d.val0 = count;
                        else
                            s_d.val1 = count;
                    end
                end
                default:
                begin
                    if (s_q.toggle_on_overflow[i] && s_q.max_act[i])
                        s_d.pin_q[i] = 1'b1;
                    else if (s_q.toggle_on_overflow[i] && overflow)
                        s_d.pin_q[i] = ~s_q.pin_q[i];
                    else if (match[i])
                        s_d.pin_q[i] = match_level(el[i], s_q.pin_q[i]);
                    if (match[i])
                    begin
                        s_d.flag[i]       = 1'b1;
                        s_d.flag_armed[i] = 1'b0;
                        ev[i]             = 1'b1;
                    end
                end
            endcase
        end
        // ahb data phase
        s_d.ahb_pend = {take, take & hwrite};
        s_d.ahb_addr = haddr;
        if (s_q.ahb_pend[1] && s_q.ahb_pend[0])
        begin
            unique case (s_q.ahb_addr)
                tcc_pkg::CH0_CTRL_ADDR, tcc_pkg::CH1_CTRL_ADDR:
                begin
                    c = (s_q.ahb_addr == tcc_pkg::CH1_CTRL_ADDR) ? 1 : 0;
                    if (c == 0 || !s_q.chan0_buffer_select)
                    begin
                        // clear only after an armed read; a new event always wins
                        if (!wb[tcc_pkg::FLAG_BIT] && s_q.flag_armed[c] && !ev[c])
                            s_d.flag[c] = 1'b0;
                        s_d.flag_armed[c]             = 1'b0;
                        s_d.irq_en[c]                 = wb[tcc_pkg::IE_BIT];
                        s_d.unbuffered_mode_select[c] = wb[tcc_pkg::MSA_BIT];
                        s_d.edge_level_select_hi[c]   = wb[tcc_pkg::ELSB_BIT];
                        s_d.edge_level_select_lo[c]   = wb[tcc_pkg::ELSA_BIT];
                        s_d.toggle_on_overflow[c]     = wb[tcc_pkg::TOV_BIT];
                        s_d.max_duty_force[c]         = wb[tcc_pkg::MAX_BIT];
                        if (c == 0)
                            s_d.chan0_buffer_select = wb[tcc_pkg::MSB_BIT];
                    end
                end
                tcc_pkg::CH0_HI_ADDR:
                begin
                    s_d.hi_wbuf0     = wb;
                    s_d.hi_wbuf_v[0] = 1'b1;
                    s_d.cmp_block[0] = md[0] != tcc_pkg::MODE_CAPTURE;
                end
                tcc_pkg::CH1_HI_ADDR:
                begin
                    s_d.hi_wbuf1     = wb;
                    s_d.hi_wbuf_v[1] = 1'b1;
                    s_d.cmp_block[1] = md[0] == tcc_pkg::MODE_BUFFERED
                                    || md[1] != tcc_pkg::MODE_CAPTURE;
                end
                tcc_pkg::CH0_LO_ADDR:
                begin
                    s_d.val0         = {s_q.hi_wbuf_v[0] ? s_q.hi_wbuf0 : s_q.val0[15:8], wb};
                    s_d.hi_wbuf_v[0] = 1'b0;
                    s_d.cmp_block[0] = 1'b0;
                end
                tcc_pkg::CH1_LO_ADDR:
                begin
                    s_d.val1         = {s_q.hi_wbuf_v[1] ? s_q.hi_wbuf1 : s_q.val1[15:8], wb};
                    s_d.hi_wbuf_v[1] = 1'b0;
                    s_d.cmp_block[1] = 1'b0;
                end
                default: ;
            endcase
        end
        // register read data, captured in address phase
        s_d.rdata = '0;
        if (take && !hwrite)
        begin
            unique case (haddr)
                tcc_pkg::CH0_CTRL_ADDR:
                begin
                    s_d.rdata[7:0] = {s_q.flag[0], s_q.irq_en[0], s_q.chan0_buffer_select,
                                      s_q.unbuffered_mode_select[0], el0,
                                      s_q.toggle_on_overflow[0], s_q.max_duty_force[0]};
                    s_d.flag_armed[0] = s_q.flag[0];
                end
                tcc_pkg::CH1_CTRL_ADDR:
                begin
                    if (!s_q.chan0_buffer_select)
                        s_d.rdata[7:0] = {s_q.flag[1], s_q.irq_en[1], 1'b0,
                                          s_q.unbuffered_mode_select[1], el1,
                                          s_q.toggle_on_overflow[1], s_q.max_duty_force[1]};
                    s_d.flag_armed[1] = s_q.flag[1] && !s_q.chan0_buffer_select;
                end
                tcc_pkg::CH0_HI_ADDR:
                begin
                    s_d.rdata[7:0] = s_q.val0[15:8];
                    s_d.lo_latch0  = s_q.val0[7:0];
                    s_d.cap_block[0] = md[0] == tcc_pkg::MODE_CAPTURE;
                end
                tcc_pkg::CH1_HI_ADDR:
                begin
                    s_d.rdata[7:0] = s_q.val1[15:8];
                    s_d.lo_latch1  = s_q.val1[7:0];
                    s_d.cap_block[1] = md[1] == tcc_pkg::MODE_CAPTURE;
                end
                tcc_pkg::CH0_LO_ADDR:
                begin
                    s_d.rdata[7:0] = s_q.cap_block[0] ? s_q.lo_latch0 : s_q.val0[7:0];
                    s_d.cap_block[0] = 1'b0;
                end
                tcc_pkg::CH1_LO_ADDR:
                begin
                    s_d.rdata[7:0] = s_q.cap_block[1] ? s_q.lo_latch1 : s_q.val1[7:0];
                    s_d.cap_block[1] = 1'b0;
                end
                default: ;
            endcase
        end
        // interrupt requests
        s_d.irq = s_d.flag & s_d.irq_en;
    end

    // state register; value registers reset only for determinism of control
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    // outputs straight from flip-flops; ready and response are tied to constants
    assign hrdata          = s_q.rdata;
    assign hreadyout       = 1'b1;
    assign hresp           = 1'b0;
    assign channel_pin_out = s_q.pin_q;
    assign channel_pin_oe  = s_q.pin_oe;
    assign chan_irq        = s_q.irq;

    // checks
    flag_set_a: assert property (@(posedge mclk) disable iff (rst)
        (mode0 == tcc_pkg::MODE_COMPARE && count == s_q.val0 && !s_q.cmp_block[0])
        |=> s_q.flag[0]) else $error("compare match did not set flag");
    irq_gate_a: assert property (@(posedge mclk) disable iff (rst)
        chan_irq[0] == (s_q.flag[0] & s_q.irq_en[0]))
        else $error("irq not gated by enable");
    port_oe_a: assert property (@(posedge mclk) disable iff (rst)
        (mode1 == tcc_pkg::MODE_PORT) ##1 (mode1 == tcc_pkg::MODE_PORT) |-> !channel_pin_oe[1])
        else $error("port mode pin driven");
    buf_free_a: assert property (@(posedge mclk) disable iff (rst)
        s_q.chan0_buffer_select |-> mode1 == tcc_pkg::MODE_PORT)
        else $error("channel 1 active in buffered mode");
    ovf_win_a: assert property (@(posedge mclk) disable iff (rst)
        (mode0 == tcc_pkg::MODE_COMPARE && s_q.toggle_on_overflow[0] && !s_q.max_act[0]
         && overflow) |=> channel_pin_out[0] != $past(channel_pin_out[0]))
        else $error("overflow toggle lost");
    full_duty_a: assert property (@(posedge mclk) disable iff (rst)
        (mode0 == tcc_pkg::MODE_COMPARE && s_q.toggle_on_overflow[0] && s_q.max_act[0])
        |=> channel_pin_out[0]) else $error("full duty not held");
    cap_hold_a: assert property (@(posedge mclk) disable iff (rst)
        (s_q.cap_block[0] && !(s_q.ahb_pend[1] && s_q.ahb_pend[0])) |=> $stable(s_q.val0))
        else $error("capture while blocked");
    cmp_hold_a: assert property (@(posedge mclk) disable iff (rst)
        (s_q.cmp_block[0] && mode0 == tcc_pkg::MODE_COMPARE && !s_q.flag[0]
         && !s_q.ahb_pend[1]) |=> !s_q.flag[0])
        else $error("match while blocked");
    max_lat_a: assert property (@(posedge mclk) disable iff (rst)
        !overflow |=> s_q.max_act == $past(s_q.max_act))
        else $error("max duty changed mid period");
    // the flag may only drop after a read that saw it set
    flag_keep_a: assert property (@(posedge mclk) disable iff (rst)
        (s_q.flag[0] && !s_q.flag_armed[0]) |=> s_q.flag[0])
        else $error("flag cleared without armed read");
    // a capture channel leaves its pin to the outside driver
    cap_oe_a: assert property (@(posedge mclk) disable iff (rst)
        (mode1 == tcc_pkg::MODE_CAPTURE) ##1 (mode1 == tcc_pkg::MODE_CAPTURE)
        |-> !channel_pin_oe[1]) else $error("capture pin driven");
    cap_cov_c: cover property (@(posedge mclk) mode0 == tcc_pkg::MODE_CAPTURE ##1 s_q.flag[0]);
    cmp_cov_c: cover property (@(posedge mclk) mode1 == tcc_pkg::MODE_COMPARE ##1 s_q.flag[1]);
    buf_cov_c: cover property (@(posedge mclk) mode0 == tcc_pkg::MODE_BUFFERED && overflow);
    clr_cov_c: cover property (@(posedge mclk) s_q.flag[0] ##1 !s_q.flag[0]);
endmodule : tcc_channels

// ---- bench/pin_model.sv ----
// model of the external driver on the two channel pins
module pin_model
(
    // clock
    input  wire logic       mclk,
    // level requested by the bench and the design's drive enables
    input  wire logic [1:0] level,
    input  wire logic [1:0] dut_oe,
    // external drive onto the pins
    output logic      [1:0] ext_level,
    output logic      [1:0] ext_en
);
    timeunit 1ns;
    timeprecision 100ps;

    // levels move only on a clock edge and are held until asked again
    always_ff @(posedge mclk)
    begin
        ext_level <= level;
    end

    // let go of a pin whenever the channel drives it
    assign ext_en = ~dut_oe;
endmodule : pin_model

// ---- bench/testbench.sv ----
// self-checking bench: register accesses, counter stimulus and pin checks
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic        mclk, rst, hsel, hwrite, hready, overflow, run;
    logic [7:0]  haddr;
    logic [1:0]  htrans, lvl, oe, pout, ext, ext_en, irq, pin;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, r;
    logic [15:0] count, cnt_set;
    logic        hreadyout, hresp, p;
    int          miscompares, compares, cyc;

    tcc_channels dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .count(count), .overflow(overflow),
        .channel_pin_in(pin), .channel_pin_out(pout), .channel_pin_oe(oe), .chan_irq(irq));
    pin_model partner (.mclk(mclk), .level(lvl), .dut_oe(oe), .ext_level(ext), .ext_en(ext_en));

    // wire level: design drive, else external drive, else pull-up
    assign pin = (oe & pout) | (~oe & ((ext_en & ext) | ~ext_en));
    // the only slave's ready is the bus ready
    assign hready = hreadyout;

    // clock, and a cycle limit that ends a hang
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            summarize();
        end
    end

    // shared counter with modulo 0x3f; overflow pulses as it reaches it; halted, it loads cnt_set
    always @(posedge mclk)
    begin
        if (run)
        begin
            count    <= (count == 16'h003f) ? 16'h0000 : count + 16'h0001;
            overflow <= (count == 16'h003e);
        end
        else
        begin
            count    <= cnt_set;
            overflow <= 1'b0;
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // one single ahb-lite transfer, address phase then data phase
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk);
        hsel   <= 1'b1;
        htrans <= tcc_pkg::HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= w;
        hsize  <= 3'h2;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string nm);
        bus(a, 1'b0, 32'h0000_0000);
        chk(nm, r & m, e);
    endtask : rc

    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask : wt

    // one capture edge on channel 1: drive level v, let the synchroniser settle
    task automatic edge1(input logic v);
        lvl[1] <= v;
        wt(8);
    endtask : edge1

    task automatic summarize();
        if (miscompares == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    initial
    begin
        {hsel, hwrite, htrans, haddr, hsize, hwdata, run, cnt_set} = '0;
        lvl    = 2'b11;
        rst    = 1'b1;
        wt(6);
        rst <= 1'b0;
        rc(tcc_pkg::CH0_CTRL_ADDR, 32'h0000_00ff, 32'h0000_0000, "ch0_ctrl");
        rc(tcc_pkg::CH1_CTRL_ADDR, 32'h0000_00ff, 32'h0000_0000, "ch1_ctrl");
        rc(8'h18, 32'hffff_ffff, 32'h0000_0000, "unmapped");
        chk("pin_oe", {30'h0, oe}, 32'h0000_0000);
        // compare: clear, then set, on a match at 0x0010
        run <= 1'b1;
        wr(tcc_pkg::CH0_HI_ADDR, 32'h0000_0000);
        wr(tcc_pkg::CH0_LO_ADDR, 32'h0000_0010);
        for (int c = 2; c <= 3; c++)
        begin
            wr(tcc_pkg::CH0_CTRL_ADDR, 32'h0000_0010 | (c << 2));
            wt(70);
            chk("pin0", {31'h0, pin[0]}, c & 1);
        end
        rc(tcc_pkg::CH0_CTRL_ADDR, 32'h0000_0080, 32'h0000_0080, "flag0");
        chk("irq0", {30'h0, irq}, 32'h0000_0000);
        wr(tcc_pkg::CH0_CTRL_ADDR, 32'h0000_0014);
        p = pin[0];
        wt(64);
        chk("pin0_tgl", {31'h0, pin[0]}, {31'h0, ~p});
        // flag clearing and interrupt request with the counter halted
        run <= 1'b0;
        wt(1);
        cnt_set <= 16'h0030;
        wr(tcc_pkg::CH0_CTRL_ADDR, 32'h0000_00d4);
        wt(1);
        chk("irq0_on", {30'h0, irq}, 32'h0000_0001);
        rc(tcc_pkg::CH0_CTRL_ADDR, 32'h0000_0080, 32'h0000_0080, "flag0_rd");
        wr(tcc_pkg::CH0_CTRL_ADDR, 32'h0000_0054);
        rc(tcc_pkg::CH0_CTRL_ADDR, 32'h0000_0080, 32'h0000_0000, "flag0_clr");
        chk("irq0_off", {30'h0, irq}, 32'h0000_0000);
        // capture on channel 1, rising edges only
        wr(tcc_pkg::CH0_CTRL_ADDR, 32'h0000_0000);
        cnt_set <= 16'h0025;
        wt(3);
        wr(tcc_pkg::CH1_CTRL_ADDR, 32'h0000_0004);
        edge1(1'b0);
        rc(tcc_pkg::CH1_CTRL_ADDR, 32'h0000_0080, 32'h0000_0000, "fall_ign");
        edge1(1'b1);
        rc(tcc_pkg::CH1_CTRL_ADDR, 32'h0000_0080, 32'h0000_0080, "flag1");
        rc(tcc_pkg::CH1_HI_ADDR, 32'h0000_00ff, 32'h0000_0000, "cap_hi");
        rc(tcc_pkg::CH1_LO_ADDR, 32'h0000_00ff, 32'h0000_0025, "cap_lo");
        // a high-byte read holds off captures until the low byte is read
        rc(tcc_pkg::CH1_HI_ADDR, 32'h0000_00ff, 32'h0000_0000, "hold_hi");
        cnt_set <= 16'h0044;
        edge1(1'b0);
        edge1(1'b1);
        rc(tcc_pkg::CH1_LO_ADDR, 32'h0000_00ff, 32'h0000_0025, "hold_lo");
        edge1(1'b0);
        edge1(1'b1);
        rc(tcc_pkg::CH1_HI_ADDR, 32'h0000_00ff, 32'h0000_0000, "new_hi");
        rc(tcc_pkg::CH1_LO_ADDR, 32'h0000_00ff, 32'h0000_0044, "new_lo");
        // falling-edge code, then either edge
        wr(tcc_pkg::CH1_CTRL_ADDR, 32'h0000_0008);
        cnt_set <= 16'h0055;
        edge1(1'b0);
        rc(tcc_pkg::CH1_HI_ADDR, 32'h0000_00ff, 32'h0000_0000, "fall_hi");
        rc(tcc_pkg::CH1_LO_ADDR, 32'h0000_00ff, 32'h0000_0055, "fall_lo");
        wr(tcc_pkg::CH1_CTRL_ADDR, 32'h0000_000c);
        cnt_set <= 16'h0066;
        edge1(1'b1);
        rc(tcc_pkg::CH1_HI_ADDR, 32'h0000_00ff, 32'h0000_0000, "both_hi");
        rc(tcc_pkg::CH1_LO_ADDR, 32'h0000_00ff, 32'h0000_0066, "both_lo");
        // buffer select on channel 0 locks out channel 1
        wr(tcc_pkg::CH0_CTRL_ADDR, 32'h0000_002c);
        rc(tcc_pkg::CH1_CTRL_ADDR, 32'h0000_00ff, 32'h0000_0000, "ch1_off");
        wr(tcc_pkg::CH1_CTRL_ADDR, 32'h0000_001c);
        rc(tcc_pkg::CH1_CTRL_ADDR, 32'h0000_00ff, 32'h0000_0000, "ch1_wr");
        chk("pin1_oe", {31'h0, oe[1]}, 32'h0000_0000);
        // toggle on overflow with a compare value that never matches
        cnt_set <= 16'h0000;
        wr(tcc_pkg::CH0_HI_ADDR, 32'h0000_00ff);
        wr(tcc_pkg::CH0_LO_ADDR, 32'h0000_00ff);
        wr(tcc_pkg::CH0_CTRL_ADDR, 32'h0000_0016);
        run <= 1'b1;
        wt(10);
        p = pin[0];
        wt(64);
        chk("pin0_ovf", {31'h0, pin[0]}, {31'h0, ~p});
        // full duty forced, then released more than three periods later
        wr(tcc_pkg::CH0_CTRL_ADDR, 32'h0000_0017);
        wt(200);
        chk("duty_a", {31'h0, pin[0]}, 32'h0000_0001);
        wt(32);
        chk("duty_b", {31'h0, pin[0]}, 32'h0000_0001);
        wr(tcc_pkg::CH0_CTRL_ADDR, 32'h0000_0016);
        wt(200);
        p = pin[0];
        wt(64);
        chk("duty_off", {31'h0, pin[0]}, {31'h0, ~p});
        summarize();
    end
endmodule : testbench
